// [src/mgp_pkg.sv]
// shared constants and types for the multiplexed gpio ports
package mgp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // widths and register selects
  localparam int MGP_PORT_W = 8;
  localparam int MGP_SEL_W = 4;
  localparam logic [3:0] MGP_REG_D_PINS = 4'h0;
  localparam logic [3:0] MGP_REG_D_LATCH = 4'h1;
  localparam logic [3:0] MGP_REG_D_DIR = 4'h2;
  localparam logic [3:0] MGP_REG_E_PINS = 4'h3;
  localparam logic [3:0] MGP_REG_E_LATCH = 4'h4;
  localparam logic [3:0] MGP_REG_E_DIR = 4'h5;
  localparam logic [3:0] MGP_REG_F_PINS = 4'h6;
  localparam logic [3:0] MGP_REG_F_LATCH = 4'h7;
  localparam logic [3:0] MGP_REG_F_DIR = 4'h8;
  localparam logic [3:0] MGP_REG_SLAVE_CTL = 4'h9;
  localparam logic [3:0] MGP_REG_MEM_CTL = 4'hA;
  localparam logic [3:0] MGP_REG_F_DIGITAL = 4'hB;

  ////////////////////////////////////////////////////////////////////////////
  // reset values, masks and field positions
  localparam logic [7:0] MGP_DIR_RST = 8'hFF;
  localparam logic [7:0] MGP_LATCH_RST = 8'h00;
  localparam logic [7:0] MGP_CTL_RST = 8'h00;
  localparam logic [7:0] MGP_F_DIGITAL_RST = 8'h00;
  localparam logic [7:0] MGP_MEM_CTL_MASK = 8'hB3;
  localparam logic [7:0] MGP_SLAVE_CTL_MASK = 8'h10;
  localparam logic [7:0] MGP_ZERO = 8'h00;
  localparam logic [7:0] MGP_ONES = 8'hFF;
  localparam logic [2:0] MGP_CTL_IN = 3'h0;
  localparam logic [2:0] MGP_CTL_IDLE = 3'h7;
  localparam int MGP_EXT_BUS_DIS_BIT = 7;
  localparam int MGP_SLAVE_MODE_BIT = 4;
  localparam int MGP_RD_STB_BIT = 0;
  localparam int MGP_WR_STB_BIT = 1;
  localparam int MGP_CS_BIT = 2;
  localparam int MGP_CCP2_BIT = 7;
  localparam int MGP_ANALOG_HI = 6;

  ////////////////////////////////////////////////////////////////////////////
  // host strobe timing in core clock cycles
  localparam int MGP_STROBE_CYCLES = 8;
  localparam int MGP_STROBE_MIN = 6;
  localparam int MGP_RECOVER_CYCLES = 4;
  localparam int MGP_RECOVER_MIN = 3;
  localparam int MGP_CNT_MAX = 255;

  typedef enum logic [1:0] {
    MGP_MODE_MCU = 2'h0,
    MGP_MODE_EXT_MCU = 2'h1,
    MGP_MODE_MPU = 2'h2,
    MGP_MODE_MPU_BOOT = 2'h3
  } mgp_mode_t;

  typedef enum logic [1:0] {
    MGP_HOST_IDLE = 2'h0,
    MGP_HOST_STROBE = 2'h1,
    MGP_HOST_RECOVER = 2'h3
  } mgp_host_state_t;

endpackage

// [src/mgp_if.sv]
// pin-level carrier between the port device and the external host
interface mgp_if;
  logic [7:0] dev_d_out;
  logic [7:0] dev_d_oe;
  logic [7:0] dev_e_out;
  logic [7:0] dev_e_oe;
  logic [7:0] dev_f_out;
  logic [7:0] dev_f_oe;
  logic [7:0] host_d_out;
  logic [7:0] host_d_oe;
  logic [7:0] host_e_out;
  logic [7:0] host_e_oe;
  logic [7:0] host_f_out;
  logic [7:0] host_f_oe;
  logic [7:0] d_level;
  logic [7:0] e_level;
  logic [7:0] f_level;

  // device driver wins, then host, else a weak pull-up
  assign d_level = (dev_d_oe & dev_d_out) | (~dev_d_oe & host_d_oe & host_d_out) | ~(dev_d_oe | host_d_oe);
  assign e_level = (dev_e_oe & dev_e_out) | (~dev_e_oe & host_e_oe & host_e_out) | ~(dev_e_oe | host_e_oe);
  assign f_level = (dev_f_oe & dev_f_out) | (~dev_f_oe & host_f_oe & host_f_out) | ~(dev_f_oe | host_f_oe);

  modport device (
    output dev_d_out, dev_d_oe, dev_e_out, dev_e_oe, dev_f_out, dev_f_oe,
    input d_level, e_level, f_level
  );

  modport host (
    output host_d_out, host_d_oe, host_e_out, host_e_oe, host_f_out, host_f_oe,
    input d_level, e_level, f_level
  );
endinterface

// [src/mgp_device.sv]
// port d, e and f logic with bus, slave port and peripheral sharing

// Behaviour
// - direction one turns pin driver off
// - direction zero drives latch value onto pin
// - latch register reads return latched value
// - pins register reads pins, writes latch
// - every reset sets direction registers all ones
// - port d general only while bus disabled
// - active external bus uses port d low byte
// - slave mode bit makes port d slave data
// - 80-pin port e general only while bus disabled
// - processor modes use port e high byte
// - slave mode makes e2..e0 strobe inputs
// - software sets e2..e0 inputs, digital first
// - selected low read strobe presents port d
// - selected low write strobe captures port d
// - chip select low selects, else strobes ignored
// - microcontroller mode, select clear, e7 carries ccp2
// - extended mode 80-pin port e starts bus
// - port f low pins read zero until digital
// - software disables comparators, analog, before digital f
// - peripheral override never written into direction
module mgp_device import mgp_pkg::*; #(
  parameter bit IS_80PIN = 1'b1
) (
  input wire logic core_clk_in,
  input wire logic reset_in,
  mgp_if.device pins,
  input wire mgp_mode_t proc_mode_in,
  input wire logic capture2_pin_select_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [MGP_SEL_W-1:0] reg_sel_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  input wire logic [15:0] ext_ad_out_in,
  input wire logic ext_ad_oe_in,
  output logic [15:0] ext_ad_in_out,
  input wire logic ccp2_out_in,
  input wire logic ccp2_oe_in,
  output logic ccp2_in_out,
  output logic ext_bus_active_out,
  output logic slave_port_active_out
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [7:0] d_meta_q;
  logic [7:0] d_sync_q;
  logic [7:0] e_meta_q;
  logic [7:0] e_sync_q;
  logic [7:0] f_meta_q;
  logic [7:0] f_sync_q;

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      d_meta_q <= MGP_ZERO;
      d_sync_q <= MGP_ZERO;
      e_meta_q <= MGP_ZERO;
      e_sync_q <= MGP_ZERO;
      f_meta_q <= MGP_ZERO;
      f_sync_q <= MGP_ZERO;
    end else begin
      d_meta_q <= pins.d_level;
      d_sync_q <= d_meta_q;
      e_meta_q <= pins.e_level;
      e_sync_q <= e_meta_q;
      f_meta_q <= pins.f_level;
      f_sync_q <= f_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software registers
  logic [7:0] d_lat_q;
  logic [7:0] d_dir_q;
  logic [7:0] e_lat_q;
  logic [7:0] e_dir_q;
  logic [7:0] f_lat_q;
  logic [7:0] f_dir_q;
  logic [7:0] f_dig_q;
  logic [7:0] mem_ctl_q;
  logic [7:0] slave_ctl_q;

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      d_dir_q <= MGP_DIR_RST;
      e_dir_q <= MGP_DIR_RST;
      f_dir_q <= MGP_DIR_RST;
    end else if (reg_wr_in) begin
      if (reg_sel_in == MGP_REG_D_DIR) begin
        d_dir_q <= reg_wdata_in;
      end
      if (reg_sel_in == MGP_REG_E_DIR) begin
        e_dir_q <= reg_wdata_in;
      end
      if (reg_sel_in == MGP_REG_F_DIR) begin
        f_dir_q <= reg_wdata_in;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      d_lat_q <= MGP_LATCH_RST;
      e_lat_q <= MGP_LATCH_RST;
      f_lat_q <= MGP_LATCH_RST;
    end else if (reg_wr_in) begin
      if (reg_sel_in == MGP_REG_D_PINS || reg_sel_in == MGP_REG_D_LATCH) begin
        d_lat_q <= reg_wdata_in;
      end
      if (reg_sel_in == MGP_REG_E_PINS || reg_sel_in == MGP_REG_E_LATCH) begin
        e_lat_q <= reg_wdata_in;
      end
      if (reg_sel_in == MGP_REG_F_PINS || reg_sel_in == MGP_REG_F_LATCH) begin
        f_lat_q <= reg_wdata_in;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      mem_ctl_q <= MGP_CTL_RST;
      slave_ctl_q <= MGP_CTL_RST;
      f_dig_q <= MGP_F_DIGITAL_RST;
    end else if (reg_wr_in) begin
      if (reg_sel_in == MGP_REG_MEM_CTL) begin
        mem_ctl_q <= reg_wdata_in & MGP_MEM_CTL_MASK;
      end
      if (reg_sel_in == MGP_REG_SLAVE_CTL) begin
        slave_ctl_q <= reg_wdata_in & MGP_SLAVE_CTL_MASK;
      end
      if (reg_sel_in == MGP_REG_F_DIGITAL) begin
        f_dig_q <= reg_wdata_in;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin ownership
  logic ext_bus_on;
  logic slv_on;
  logic ccp2_alt;
  logic slv_rd;
  logic slv_wr;
  logic [7:0] slv_buf_q;

  // bus disable bit clears at reset, so processor modes start on the bus
  assign ext_bus_on = IS_80PIN && proc_mode_in != MGP_MODE_MCU && !mem_ctl_q[MGP_EXT_BUS_DIS_BIT];
  assign slv_on = slave_ctl_q[MGP_SLAVE_MODE_BIT] && !ext_bus_on;
  assign ccp2_alt = proc_mode_in == MGP_MODE_MCU && !capture2_pin_select_in;
  assign slv_rd = slv_on && !e_sync_q[MGP_CS_BIT] && !e_sync_q[MGP_RD_STB_BIT];
  assign slv_wr = slv_on && !e_sync_q[MGP_CS_BIT] && !e_sync_q[MGP_WR_STB_BIT];

  // data and strobe share one sync depth, so the last strobed byte stays
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      slv_buf_q <= MGP_ZERO;
    end else if (slv_wr) begin
      slv_buf_q <= d_sync_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drivers
  logic [7:0] e_out_d;
  logic [7:0] e_oe_d;

  always_comb begin
    e_out_d = e_lat_q;
    e_oe_d = ~e_dir_q;
    if (ccp2_alt) begin
      e_out_d[MGP_CCP2_BIT] = ccp2_out_in;
      e_oe_d[MGP_CCP2_BIT] = ccp2_oe_in;
    end
    if (slv_on) begin
      e_oe_d[MGP_CS_BIT:MGP_RD_STB_BIT] = MGP_CTL_IN;
    end
    if (ext_bus_on) begin
      e_out_d = ext_ad_out_in[15:8];
      e_oe_d = {8{ext_ad_oe_in}};
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      pins.dev_d_out <= MGP_ZERO;
      pins.dev_d_oe <= MGP_ZERO;
    end else if (ext_bus_on) begin
      pins.dev_d_out <= ext_ad_out_in[7:0];
      pins.dev_d_oe <= {8{ext_ad_oe_in}};
    end else if (slv_on) begin
      pins.dev_d_out <= d_lat_q;
      pins.dev_d_oe <= {8{slv_rd}};
    end else begin
      pins.dev_d_out <= d_lat_q;
      pins.dev_d_oe <= ~d_dir_q;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      pins.dev_e_out <= MGP_ZERO;
      pins.dev_e_oe <= MGP_ZERO;
      pins.dev_f_out <= MGP_ZERO;
      pins.dev_f_oe <= MGP_ZERO;
    end else begin
      pins.dev_e_out <= e_out_d;
      pins.dev_e_oe <= e_oe_d;
      pins.dev_f_out <= f_lat_q;
      pins.dev_f_oe <= ~f_dir_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register reads and status outputs
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      reg_rdata_out <= MGP_ZERO;
    end else if (reg_rd_in) begin
      unique case (reg_sel_in)
        MGP_REG_D_PINS: reg_rdata_out <= slv_on ? slv_buf_q : d_sync_q;
        MGP_REG_D_LATCH: reg_rdata_out <= d_lat_q;
        MGP_REG_D_DIR: reg_rdata_out <= d_dir_q;
        MGP_REG_E_PINS: reg_rdata_out <= e_sync_q;
        MGP_REG_E_LATCH: reg_rdata_out <= e_lat_q;
        MGP_REG_E_DIR: reg_rdata_out <= e_dir_q;
        MGP_REG_F_PINS: reg_rdata_out <= {f_sync_q[7], f_sync_q[MGP_ANALOG_HI:0] & f_dig_q[MGP_ANALOG_HI:0]};
        MGP_REG_F_LATCH: reg_rdata_out <= f_lat_q;
        MGP_REG_F_DIR: reg_rdata_out <= f_dir_q;
        MGP_REG_SLAVE_CTL: reg_rdata_out <= slave_ctl_q;
        MGP_REG_MEM_CTL: reg_rdata_out <= mem_ctl_q;
        MGP_REG_F_DIGITAL: reg_rdata_out <= f_dig_q;
        default: reg_rdata_out <= MGP_ZERO;
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      ext_ad_in_out <= {MGP_ZERO, MGP_ZERO};
      ccp2_in_out <= 1'b0;
      ext_bus_active_out <= 1'b0;
      slave_port_active_out <= 1'b0;
    end else begin
      ext_ad_in_out <= {e_sync_q, d_sync_q};
      ccp2_in_out <= e_sync_q[MGP_CCP2_BIT];
      ext_bus_active_out <= ext_bus_on;
      slave_port_active_out <= slv_on;
    end
  end

endmodule

// [src/mgp_host.sv]
// external host that drives the parallel slave port strobes and data
module mgp_host import mgp_pkg::*; #(
  parameter int STROBE_CYCLES = MGP_STROBE_CYCLES,
  parameter int RECOVER_CYCLES = MGP_RECOVER_CYCLES
) (
  input wire logic core_clk_in,
  input wire logic reset_in,
  mgp_if.host pins,
  input wire logic cmd_valid_in,
  input wire logic cmd_write_in,
  input wire logic [7:0] cmd_data_in,
  output logic cmd_ready_out,
  output logic done_out,
  output logic [7:0] rdata_out,
  input wire logic [7:0] aux_e_out_in,
  input wire logic [7:0] aux_e_oe_in,
  input wire logic [7:0] aux_f_out_in,
  input wire logic [7:0] aux_f_oe_in,
  output logic [7:0] d_level_out,
  output logic [7:0] e_level_out,
  output logic [7:0] f_level_out
);

  if (STROBE_CYCLES < MGP_STROBE_MIN || STROBE_CYCLES > MGP_CNT_MAX) begin : g_bad_strobe
    $error("strobe length out of range");
  end
  if (RECOVER_CYCLES < MGP_RECOVER_MIN || RECOVER_CYCLES > MGP_CNT_MAX) begin : g_bad_recover
    $error("recovery length out of range");
  end

  localparam logic [7:0] STROBE_LAST = 8'(STROBE_CYCLES - 1);
  localparam logic [7:0] RECOVER_LAST = 8'(RECOVER_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [7:0] d_meta_q;
  logic [7:0] d_sync_q;
  logic [7:0] e_meta_q;
  logic [7:0] e_sync_q;
  logic [7:0] f_meta_q;
  logic [7:0] f_sync_q;

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      d_meta_q <= MGP_ZERO;
      d_sync_q <= MGP_ZERO;
      e_meta_q <= MGP_ZERO;
      e_sync_q <= MGP_ZERO;
      f_meta_q <= MGP_ZERO;
      f_sync_q <= MGP_ZERO;
    end else begin
      d_meta_q <= pins.d_level;
      d_sync_q <= d_meta_q;
      e_meta_q <= pins.e_level;
      e_sync_q <= e_meta_q;
      f_meta_q <= pins.f_level;
      f_sync_q <= f_meta_q;
    end
  end

  assign d_level_out = d_sync_q;
  assign e_level_out = e_sync_q;
  assign f_level_out = f_sync_q;

  ////////////////////////////////////////////////////////////////////////////
  // strobe sequencer
  mgp_host_state_t state_q;
  logic [7:0] cnt_q;
  logic write_q;
  logic [7:0] wdata_q;

  assign cmd_ready_out = state_q == MGP_HOST_IDLE;

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      state_q <= MGP_HOST_IDLE;
      cnt_q <= MGP_ZERO;
      write_q <= 1'b0;
      wdata_q <= MGP_ZERO;
      done_out <= 1'b0;
      rdata_out <= MGP_ZERO;
    end else begin
      done_out <= 1'b0;
      unique case (state_q)
        MGP_HOST_IDLE: begin
          cnt_q <= MGP_ZERO;
          if (cmd_valid_in) begin
            state_q <= MGP_HOST_STROBE;
            write_q <= cmd_write_in;
            wdata_q <= cmd_data_in;
          end
        end
        MGP_HOST_STROBE: begin
          cnt_q <= cnt_q + 8'h01;
          if (cnt_q == STROBE_LAST) begin
            cnt_q <= MGP_ZERO;
            state_q <= MGP_HOST_RECOVER;
            if (!write_q) begin
              rdata_out <= d_sync_q;
            end
          end
        end
        MGP_HOST_RECOVER: begin
          cnt_q <= cnt_q + 8'h01;
          if (cnt_q == RECOVER_LAST) begin
            state_q <= MGP_HOST_IDLE;
            done_out <= 1'b1;
          end
        end
        default: state_q <= MGP_HOST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drivers
  logic strobe_on;
  logic [2:0] ctl_d;

  assign strobe_on = state_q == MGP_HOST_STROBE;

  always_comb begin
    ctl_d = MGP_CTL_IDLE;
    if (strobe_on) begin
      ctl_d[MGP_CS_BIT] = 1'b0;
      ctl_d[MGP_RD_STB_BIT] = write_q;
      ctl_d[MGP_WR_STB_BIT] = !write_q;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      pins.host_d_out <= MGP_ZERO;
      pins.host_d_oe <= MGP_ZERO;
      pins.host_e_out <= MGP_ONES;
      pins.host_e_oe <= MGP_ONES;
      pins.host_f_out <= MGP_ZERO;
      pins.host_f_oe <= MGP_ZERO;
    end else begin
      pins.host_d_out <= wdata_q;
      pins.host_d_oe <= {8{write_q && state_q != MGP_HOST_IDLE}};
      pins.host_e_out <= {aux_e_out_in[7:3], ctl_d};
      pins.host_e_oe <= {aux_e_oe_in[7:3], 3'h7};
      pins.host_f_out <= aux_f_out_in;
      pins.host_f_oe <= aux_f_oe_in;
    end
  end

endmodule

// [sim/mgp_sva.sv]
// assertion checker for the slave port link between device and host
module mgp_sva (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic [7:0] dev_d_oe,
  input wire logic [7:0] dev_e_oe,
  input wire logic [7:0] dev_f_oe,
  input wire logic [7:0] host_d_out,
  input wire logic [7:0] host_d_oe,
  input wire logic [7:0] host_e_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking dc @(posedge core_clk_in);
  endclocking
  default disable iff (reset_in);

  ////////////////////////////////////////////////////////////////////////////
  // sequences
  sequence s_strobe_low;
    (!host_e_out[2])[*8] ##1 host_e_out[2];
  endsequence
  sequence s_write_hold;
    (host_d_oe == 8'hFF && $stable(host_d_out))[*7];
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  // properties
  property p_reset_inputs;
    $fell(reset_in) |-> (dev_d_oe | dev_e_oe | dev_f_oe) == 8'h00;
  endproperty
  property p_strobe_hold;
    $fell(host_e_out[2]) |-> s_strobe_low;
  endproperty
  property p_recover;
    $rose(host_e_out[2]) && $past(host_e_out[1:0]) != 2'b11 |-> host_e_out[2] [*4];
  endproperty
  property p_one_strobe;
    !$past(reset_in) |-> host_e_out[1:0] != 2'b00;
  endproperty
  property p_cs_first;
    !$past(reset_in) && host_e_out[1:0] != 2'b11 |-> !host_e_out[2];
  endproperty
  property p_read_no_drive;
    !$past(reset_in) && !host_e_out[0] |-> host_d_oe == 8'h00;
  endproperty
  property p_write_drive;
    $fell(host_e_out[1]) |=> s_write_hold;
  endproperty
  property p_e_ctl_input;
    !$past(reset_in) && !host_e_out[2] |-> dev_e_oe[2:0] == 3'b000;
  endproperty
  property p_dev_read;
    $fell(host_e_out[0]) |-> ##[2:4] dev_d_oe == 8'hFF;
  endproperty

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  a_reset_inputs: assert property (p_reset_inputs)
    else $error("pins driven right after reset");
  a_strobe_hold: assert property (p_strobe_hold)
    else $error("strobe length wrong");
  a_recover: assert property (p_recover)
    else $error("select recovery too short");
  a_one_strobe: assert property (p_one_strobe)
    else $error("read and write strobes low together");
  a_cs_first: assert property (p_cs_first)
    else $error("strobe without select");
  a_read_no_drive: assert property (p_read_no_drive)
    else $error("host drives data during read");
  a_write_drive: assert property (p_write_drive)
    else $error("write data not held");
  a_e_ctl_input: assert property (p_e_ctl_input)
    else $error("device drives control pins");
  a_dev_read: assert property (p_dev_read)
    else $error("device did not present data");
endmodule

// [sim/multiplexed_gpio_ports_def_bench.sv]
// self-checking bench for the multiplexed gpio ports, device and host joined
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin err_count++; $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module multiplexed_gpio_ports_def_bench import mgp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk_in = 1'b0;
  logic reset_in = 1'b1;
  mgp_mode_t proc_mode = MGP_MODE_MCU;
  logic cap2_sel = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [3:0] reg_sel = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic [15:0] ad_out = 16'h0000;
  logic ad_oe = 1'b0;
  logic [15:0] ad_in;
  logic ccp2_out = 1'b0;
  logic ccp2_oe = 1'b0;
  logic ccp2_in, bus_act, slv_act, cmd_ready, done;
  logic cmd_valid = 1'b0;
  logic cmd_write = 1'b0;
  logic [7:0] cmd_data = 8'h00;
  logic [7:0] host_rdata;
  logic [7:0] aux_e_out = 8'h00;
  logic [7:0] aux_f_out = 8'h00;
  logic [7:0] host_d_lvl, host_e_lvl, host_f_lvl;
  int err_count = 0;
  int cmp_count = 0;
  int seed = 29;

  mgp_if mgp_if_i ();
  mgp_device mgp_device_i (.core_clk_in(core_clk_in), .reset_in(reset_in), .pins(mgp_if_i.device),
    .proc_mode_in(proc_mode), .capture2_pin_select_in(cap2_sel), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .reg_sel_in(reg_sel), .reg_wdata_in(reg_wdata), .reg_rdata_out(reg_rdata), .ext_ad_out_in(ad_out),
    .ext_ad_oe_in(ad_oe), .ext_ad_in_out(ad_in), .ccp2_out_in(ccp2_out), .ccp2_oe_in(ccp2_oe),
    .ccp2_in_out(ccp2_in), .ext_bus_active_out(bus_act), .slave_port_active_out(slv_act));
  mgp_host mgp_host_i (.core_clk_in(core_clk_in), .reset_in(reset_in), .pins(mgp_if_i.host),
    .cmd_valid_in(cmd_valid), .cmd_write_in(cmd_write), .cmd_data_in(cmd_data), .cmd_ready_out(cmd_ready),
    .done_out(done), .rdata_out(host_rdata), .aux_e_out_in(aux_e_out), .aux_e_oe_in(8'hF8),
    .aux_f_out_in(aux_f_out), .aux_f_oe_in(8'hFF), .d_level_out(host_d_lvl), .e_level_out(host_e_lvl),
    .f_level_out(host_f_lvl));
  mgp_sva mgp_sva_i (.core_clk_in(core_clk_in), .reset_in(reset_in), .dev_d_oe(mgp_if_i.dev_d_oe),
    .dev_e_oe(mgp_if_i.dev_e_oe), .dev_f_oe(mgp_if_i.dev_f_oe), .host_d_out(mgp_if_i.host_d_out),
    .host_d_oe(mgp_if_i.host_d_oe), .host_e_out(mgp_if_i.host_e_out));

  initial begin
    forever #5 core_clk_in = ~core_clk_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  // tasks and expectations
  function automatic logic [7:0] pin_exp(input logic [7:0] lat, input logic [7:0] dir, input logic [7:0] ext);
    return (lat & ~dir) | (dir & ext);
  endfunction
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic settle;
    repeat (5) @(negedge core_clk_in);
  endtask
  task automatic wr(input logic [3:0] s, input logic [7:0] d);
    @(negedge core_clk_in);
    reg_wr = 1'b1;
    reg_sel = s;
    reg_wdata = d;
    @(negedge core_clk_in);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [3:0] s, output logic [7:0] d);
    @(negedge core_clk_in);
    reg_rd = 1'b1;
    reg_sel = s;
    @(negedge core_clk_in);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask
  task automatic do_reset;
    ad_oe = 1'b0;
    ccp2_oe = 1'b0;
    reset_in = 1'b1;
    repeat (20) @(negedge core_clk_in);
    reset_in = 1'b0;
    settle();
  endtask
  task automatic xfer(input logic w, input logic [7:0] d);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 50) begin
      @(negedge core_clk_in);
      n++;
    end
    if (cmd_ready !== 1'b1) begin
      err_count++;
      $display("mismatch host ready expected 1 seen 0");
      close_out();
    end
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_data = d;
    @(negedge core_clk_in);
    cmd_valid = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 50) begin
      @(negedge core_clk_in);
      n++;
    end
    if (done !== 1'b1) begin
      err_count++;
      $display("mismatch host done expected 1 seen 0");
      close_out();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    logic [7:0] lat, dir, ext, v, oe, outv, dir_e, lvl;
    logic [15:0] ad;
    do_reset();
    for (int s = 2; s < 9; s += 3) begin
      rd(4'(s), v);
      `CHK("direction reset", MGP_DIR_RST, v)
    end
    $display("test reset values done");
    wr(MGP_REG_F_DIGITAL, 8'hFF);
    repeat (4) begin
      for (int p = 0; p < 3; p++) begin
        lat = 8'($random(seed));
        dir = 8'($random(seed));
        aux_e_out = 8'($random(seed));
        aux_f_out = 8'($random(seed));
        ext = (p == 0) ? 8'hFF : (p == 1) ? {aux_e_out[7:3], 3'b111} : aux_f_out;
        if (p == 1) dir_e = dir;
        wr(4'(3 * p + 1), lat);
        wr(4'(3 * p + 2), dir);
        settle();
        oe = (p == 0) ? mgp_if_i.dev_d_oe : (p == 1) ? mgp_if_i.dev_e_oe : mgp_if_i.dev_f_oe;
        outv = (p == 0) ? mgp_if_i.dev_d_out : (p == 1) ? mgp_if_i.dev_e_out : mgp_if_i.dev_f_out;
        `CHK("pin enable", ~dir, oe)
        `CHK("pin value", lat & ~dir, outv & ~dir)
        lvl = (p == 0) ? host_d_lvl : (p == 1) ? host_e_lvl : host_f_lvl;
        `CHK("host pin level", pin_exp(lat, dir, ext), lvl)
        rd(4'(3 * p + 1), v);
        `CHK("latch read", lat, v)
        rd(4'(3 * p), v);
        `CHK("pin read", pin_exp(lat, dir, ext), v)
        lat = 8'($random(seed));
        wr(4'(3 * p), lat);
        rd(4'(3 * p + 1), v);
        `CHK("pin write", lat, v)
      end
    end
    wr(MGP_REG_F_DIGITAL, 8'h00);
    settle();
    rd(MGP_REG_F_PINS, v);
    `CHK("analog pin read", pin_exp(lat, dir, ext) & 8'h80, v)
    $display("test port registers done");
    cap2_sel = 1'b0;
    ccp2_oe = 1'b1;
    for (int b = 0; b < 2; b++) begin
      ccp2_out = 1'(b);
      settle();
      `CHK("ccp2 pin", ({1'b1, 1'(b), 1'(b)}), ({mgp_if_i.dev_e_oe[7], mgp_if_i.dev_e_out[7], ccp2_in}))
    end
    rd(MGP_REG_E_DIR, v);
    `CHK("direction kept", dir_e, v)
    ccp2_oe = 1'b0;
    cap2_sel = 1'b1;
    $display("test peripheral override done");
    for (int m = 1; m < 4; m++) begin
      proc_mode = mgp_mode_t'(2'(m));
      do_reset();
      `CHK("bus at reset", 1'b1, bus_act)
      ad = 16'($random(seed));
      ad_out = ad;
      ad_oe = 1'b1;
      settle();
      `CHK("bus enable", 16'hFFFF, ({mgp_if_i.dev_e_oe, mgp_if_i.dev_d_oe}))
      `CHK("bus value", ad, ({mgp_if_i.dev_e_out, mgp_if_i.dev_d_out}))
      `CHK("bus input", ad, ad_in)
      ad_oe = 1'b0;
      wr(MGP_REG_MEM_CTL, 8'h80);
      dir = 8'($random(seed));
      wr(MGP_REG_D_DIR, dir);
      settle();
      `CHK("port general", ({1'b0, ~dir, 8'h00}), ({bus_act, mgp_if_i.dev_d_oe, mgp_if_i.dev_e_oe}))
    end
    $display("test external bus done");
    proc_mode = MGP_MODE_MCU;
    do_reset();
    wr(MGP_REG_E_DIR, MGP_DIR_RST);
    wr(MGP_REG_F_DIGITAL, MGP_ONES);
    wr(MGP_REG_SLAVE_CTL, 8'hFF);
    rd(MGP_REG_SLAVE_CTL, v);
    `CHK("slave control", MGP_SLAVE_CTL_MASK, v)
    `CHK("slave active", 1'b1, slv_act)
    repeat (4) begin
      lat = 8'($random(seed));
      xfer(1'b1, lat);
      rd(MGP_REG_D_PINS, v);
      `CHK("slave write", lat, v)
      lat = 8'($random(seed));
      wr(MGP_REG_D_LATCH, lat);
      xfer(1'b0, 8'h00);
      `CHK("slave read", lat, host_rdata)
    end
    $display("test slave port done");
    close_out();
  end
endmodule
